//--- design/sensor_link_regs.vh
// Constants for the single-wire sensor ROM layer: timing, opcodes, registers
`ifndef SENSOR_LINK_REGS_VH
`define SENSOR_LINK_REGS_VH

// Clock rate and bus timing, times in microseconds
`define CLK_MHZ           25
`define RST_LOW_US        480
`define PRES_WAIT_US      30
`define PRES_LEN_US       120
`define SLOT_SAMPLE_US    30
`define PRES_WAIT_CYC     (`PRES_WAIT_US * `CLK_MHZ)
`define PRES_LEN_CYC      (`PRES_LEN_US * `CLK_MHZ)
`define SLOT_SAMPLE_CYC   (`SLOT_SAMPLE_US * `CLK_MHZ)
`define RST_LOW_CYC       (`RST_LOW_US * `CLK_MHZ)

// ROM command opcodes
`define OP_SEARCH         8'hf0
`define OP_READ_ID        8'h33
`define OP_MATCH_ID       8'h55
`define OP_SKIP_ID        8'hcc
`define OP_ALARM_SEARCH   8'hec

// Reflected form of x^8 + x^5 + x^4 + 1
`define CRC_POLY_REFL     8'h8c

// Bit counters
`define ID_LAST_BIT       6'd63
`define BYTE_LAST_BIT     6'd7

// Identity code layout
`define FAMILY_CODE       8'h5a
`define SERIAL_W          48

// Scratchpad defaults and fixed bytes
`define CFG_RES_RST       2'b11
`define CFG_RES_HI_BIT    6
`define CFG_RES_LO_BIT    5
`define SCR_RSVD5         8'hff
`define SCR_RSVD6         8'h00
`define SCR_RSVD7         8'h10
`define TH_RST            8'h4b
`define TL_RST            8'h46
`define TEMP_RST          16'h0550

// Max conversion time per resolution, microseconds
`define CONV_US_9         20'd93750
`define CONV_US_10        20'd187500
`define CONV_US_11        20'd375000
`define CONV_US_12        20'd750000

// APB register byte offsets
`define A_SERIAL_LO       8'h00
`define A_SERIAL_HI       8'h04
`define A_ID_TOP          8'h08
`define A_TEMP            8'h0c
`define A_SCRATCH         8'h10
`define A_SCR_CRC         8'h14
`define A_STATUS          8'h18
`define A_CONV            8'h1c

// Status register fields
`define ST_FUNC_VALID     8
`define ST_ALARM          9
`define ST_ADDRESSED      10

`endif

//--- design/crc8_calc.v
// Combinational CRC-8 over a little-endian byte vector, LSB fed first
`timescale 1ns/1ps
`default_nettype none
`include "sensor_link_regs.vh"

module crc8_calc #(
	parameter NBYTES = 7
) (
	input  wire [8*NBYTES-1:0] data,
	output reg  [7:0]          crc
);
	integer i;
	reg     fb;

	// Serial shift register unrolled; starts at zero like the checker
	always @* begin
		crc = 8'h00;
		fb  = 1'b0;
		for (i = 0; i < 8*NBYTES; i = i + 1) begin
			fb  = crc[0] ^ data[i];
			crc = {1'b0, crc[7:1]};
			if (fb) begin
				crc = crc ^ `CRC_POLY_REFL;
			end
		end
	end

endmodule
`default_nettype wire

//--- design/line_watch.v
// Data line synchroniser, edge detection and long-low bus reset detector
`timescale 1ns/1ps
`default_nettype none
`include "sensor_link_regs.vh"

module line_watch #(
	parameter RESET_CYC = `RST_LOW_CYC
) (
	input  wire pclk,
	input  wire presetn,
	input  wire dq_in,
	output wire line_lvl,
	output wire fell,
	output wire rose,
	output reg  bus_rst
);
	reg        sync1_reg;
	reg        sync2_reg;
	reg        prev_reg;
	reg [15:0] low_cnt_reg;

	// Two flops before anyone looks at the pin; line idles high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end else begin
			sync1_reg <= dq_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign line_lvl = sync2_reg;
	assign fell     = prev_reg & ~sync2_reg;
	assign rose     = ~prev_reg & sync2_reg;

	// Low time counter; one pulse once the line has been low too long
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_reg <= 16'h0000;
			bus_rst     <= 1'b0;
		end else if (sync2_reg) begin
			low_cnt_reg <= 16'h0000;
			bus_rst     <= 1'b0;
		end else begin
			bus_rst <= (low_cnt_reg == RESET_CYC[15:0]);
			if (low_cnt_reg != 16'hffff) begin
				low_cnt_reg <= low_cnt_reg + 16'h0001;
			end
		end
	end

endmodule
`default_nettype wire

//--- design/sensor_link.v
// Slave-side ROM command layer of a single-wire temperature sensor
`timescale 1ns/1ps
`default_nettype none
`include "sensor_link_regs.vh"

module sensor_link #(
	parameter RESET_CYC = `RST_LOW_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        dq_in,
	output reg         dq_out,
	output reg         dq_oe
);
	// Link states
	localparam ST_IDLE      = 4'd0;
	localparam ST_WAIT_RISE = 4'd1;
	localparam ST_PRES_WAIT = 4'd2;
	localparam ST_PRES_DRV  = 4'd3;
	localparam ST_ROM_CMD   = 4'd4;
	localparam ST_SEARCH    = 4'd5;
	localparam ST_READ_ID   = 4'd6;
	localparam ST_MATCH     = 4'd7;
	localparam ST_FUNC_CMD  = 4'd8;
	localparam ST_HOLD      = 4'd9;

	reg  [3:0]  state_reg;
	reg  [15:0] time_cnt_reg;
	reg         slot_busy_reg;
	reg  [5:0]  bit_idx_reg;
	reg  [1:0]  phase_reg;
	reg  [7:0]  shift_reg;
	reg         mismatch_reg;
	reg  [7:0]  func_cmd_reg;
	reg         func_valid_reg;
	reg         addressed_reg;
	reg  [31:0] serial_lo_reg;
	reg  [15:0] serial_hi_reg;
	reg  [15:0] temp_reg;
	reg  [7:0]  th_reg;
	reg  [7:0]  tl_reg;
	reg  [1:0]  res_reg;
	reg         alarm_reg;
	reg  [31:0] rd_data;
	reg         rd_err;
	reg         tx_bit;
	reg         tx_state;

	wire        line_lvl;
	wire        fell;
	wire        rose;
	wire        bus_rst;
	wire [7:0]  id_crc;
	wire [7:0]  scr_crc;
	wire [63:0] id_code;
	wire [63:0] scratch;
	wire [7:0]  cfg_byte;
	wire        bit_done;
	wire        rx_bit;
	wire        id_bit;
	wire [7:0]  cmd_byte;
	wire        wr_en;
	wire        func_clr;

	// Decide alarm from a new conversion: whole degrees against limits
	function alarm_check;
		input [15:0] temp;
		input [7:0]  th;
		input [7:0]  tl;
		reg signed [7:0] whole;
		begin
			whole = temp[11:4];
			alarm_check = (whole > $signed(th)) || (whole < $signed(tl));
		end
	endfunction

	// Maximum conversion time in microseconds for a resolution setting
	function [19:0] conv_us;
		input [1:0] res;
		begin
			case (res)
			2'b00:   conv_us = `CONV_US_9;
			2'b01:   conv_us = `CONV_US_10;
			2'b10:   conv_us = `CONV_US_11;
			default: conv_us = `CONV_US_12;
			endcase
		end
	endfunction

	line_watch #(
		.RESET_CYC (RESET_CYC)
	) u_line (
		.pclk     (pclk),
		.presetn  (presetn),
		.dq_in    (dq_in),
		.line_lvl (line_lvl),
		.fell     (fell),
		.rose     (rose),
		.bus_rst  (bus_rst)
	);

	// Identity: family low, serial, CRC of the lower 56 bits on top
	assign id_code = {id_crc, serial_hi_reg, serial_lo_reg, `FAMILY_CODE};

	crc8_calc #(
		.NBYTES (7)
	) u_id_crc (
		.data (id_code[55:0]),
		.crc  (id_crc)
	);

	// Config byte: bit 7 zero, low five bits ones, resolution at 6:5
	assign cfg_byte = {1'b0, res_reg, 5'h1f};
	assign scratch  = {`SCR_RSVD7, `SCR_RSVD6, `SCR_RSVD5, cfg_byte,
			   tl_reg, th_reg, temp_reg};

	// Combinational, so it follows any scratchpad change at once
	crc8_calc #(
		.NBYTES (8)
	) u_scr_crc (
		.data (scratch),
		.crc  (scr_crc)
	);

	assign rx_bit   = line_lvl;
	assign id_bit   = id_code[bit_idx_reg];
	assign bit_done = slot_busy_reg &&
			  (time_cnt_reg == `SLOT_SAMPLE_CYC - 1);
	assign cmd_byte = {rx_bit, shift_reg[7:1]};

	// What the device sends in the current slot, if anything
	always @* begin
		tx_state = 1'b0;
		tx_bit   = 1'b1;
		if (state_reg == ST_SEARCH && phase_reg != 2'd2) begin
			tx_state = 1'b1;
			tx_bit   = id_bit ^ phase_reg[0];
		end else if (state_reg == ST_READ_ID) begin
			tx_state = 1'b1;
			tx_bit   = id_bit;
		end
	end

	// Link state machine. Slots start on a master falling edge only, so
	// any amount of high time between bits is harmless.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= ST_IDLE;
			time_cnt_reg   <= 16'h0000;
			slot_busy_reg  <= 1'b0;
			bit_idx_reg    <= 6'd0;
			phase_reg      <= 2'd0;
			shift_reg      <= 8'h00;
			mismatch_reg   <= 1'b0;
			func_cmd_reg   <= 8'h00;
			func_valid_reg <= 1'b0;
			addressed_reg  <= 1'b0;
			dq_oe          <= 1'b0;
			dq_out         <= 1'b0;
		end else begin
			dq_out <= 1'b0;
			if (func_clr) begin
				func_valid_reg <= 1'b0;
			end
			if (bus_rst) begin
				// Abandon everything and wait for the release
				state_reg     <= ST_WAIT_RISE;
				slot_busy_reg <= 1'b0;
				dq_oe         <= 1'b0;
				addressed_reg <= 1'b0;
			end else begin
				case (state_reg)
				ST_IDLE, ST_HOLD: begin
					// Silent until a bus reset arrives
					dq_oe <= 1'b0;
				end
				ST_WAIT_RISE: begin
					if (rose) begin
						state_reg    <= ST_PRES_WAIT;
						time_cnt_reg <= 16'h0000;
					end
				end
				ST_PRES_WAIT: begin
					time_cnt_reg <= time_cnt_reg + 16'h0001;
					if (time_cnt_reg == `PRES_WAIT_CYC - 1) begin
						state_reg    <= ST_PRES_DRV;
						time_cnt_reg <= 16'h0000;
						dq_oe        <= 1'b1;
					end
				end
				ST_PRES_DRV: begin
					time_cnt_reg <= time_cnt_reg + 16'h0001;
					if (time_cnt_reg == `PRES_LEN_CYC - 1) begin
						state_reg     <= ST_ROM_CMD;
						dq_oe         <= 1'b0;
						bit_idx_reg   <= 6'd0;
						slot_busy_reg <= 1'b0;
					end
				end
				default: begin
					if (!slot_busy_reg) begin
						if (fell) begin
							slot_busy_reg <= 1'b1;
							time_cnt_reg  <= 16'h0000;
							// Pull low only to send a zero
							dq_oe <= tx_state & ~tx_bit;
						end
					end else begin
						time_cnt_reg <= time_cnt_reg + 16'h0001;
						if (bit_done) begin
							slot_busy_reg <= 1'b0;
							dq_oe         <= 1'b0;
							case (state_reg)
							ST_ROM_CMD: begin
								shift_reg   <= cmd_byte;
								bit_idx_reg <= bit_idx_reg + 6'd1;
								if (bit_idx_reg == `BYTE_LAST_BIT) begin
									bit_idx_reg  <= 6'd0;
									phase_reg    <= 2'd0;
									mismatch_reg <= 1'b0;
									case (cmd_byte)
									`OP_SEARCH: state_reg <= ST_SEARCH;
									`OP_READ_ID: state_reg <= ST_READ_ID;
									`OP_MATCH_ID: state_reg <= ST_MATCH;
									`OP_SKIP_ID: begin
										state_reg     <= ST_FUNC_CMD;
										addressed_reg <= 1'b1;
									end
									`OP_ALARM_SEARCH: begin
										state_reg <= alarm_reg ? ST_SEARCH
												       : ST_HOLD;
									end
									default: state_reg <= ST_HOLD;
									endcase
								end
							end
							ST_SEARCH: begin
								if (phase_reg != 2'd2) begin
									phase_reg <= phase_reg + 2'd1;
								end else if (rx_bit != id_bit) begin
									state_reg <= ST_HOLD;
								end else if (bit_idx_reg == `ID_LAST_BIT) begin
									// Search never leads to a function command
									state_reg <= ST_HOLD;
								end else begin
									phase_reg   <= 2'd0;
									bit_idx_reg <= bit_idx_reg + 6'd1;
								end
							end
							ST_READ_ID: begin
								bit_idx_reg <= bit_idx_reg + 6'd1;
								if (bit_idx_reg == `ID_LAST_BIT) begin
									bit_idx_reg   <= 6'd0;
									state_reg     <= ST_FUNC_CMD;
									addressed_reg <= 1'b1;
								end
							end
							ST_MATCH: begin
								mismatch_reg <= mismatch_reg | (rx_bit != id_bit);
								bit_idx_reg  <= bit_idx_reg + 6'd1;
								if (bit_idx_reg == `ID_LAST_BIT) begin
									bit_idx_reg <= 6'd0;
									if (mismatch_reg || (rx_bit != id_bit)) begin
										state_reg <= ST_HOLD;
									end else begin
										state_reg     <= ST_FUNC_CMD;
										addressed_reg <= 1'b1;
									end
								end
							end
							ST_FUNC_CMD: begin
								shift_reg   <= cmd_byte;
								bit_idx_reg <= bit_idx_reg + 6'd1;
								if (bit_idx_reg == `BYTE_LAST_BIT) begin
									// Handed to the function layer; no CRC gate
									func_cmd_reg   <= cmd_byte;
									func_valid_reg <= 1'b1;
									state_reg      <= ST_HOLD;
								end
							end
							default: state_reg <= ST_HOLD;
							endcase
						end
					end
				end
				endcase
			end
		end
	end

	// APB: access phase always completes in one cycle
	assign wr_en    = psel & penable & pwrite & pready;
	assign func_clr = wr_en && (paddr == `A_STATUS) &&
			  pwdata[`ST_FUNC_VALID] && !(state_reg == ST_FUNC_CMD
			  && bit_done && bit_idx_reg == `BYTE_LAST_BIT);

	// Read decode; unmapped addresses read zero with an error
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		case (paddr)
		`A_SERIAL_LO: rd_data = serial_lo_reg;
		`A_SERIAL_HI: rd_data = {16'h0000, serial_hi_reg};
		`A_ID_TOP:    rd_data = {16'h0000, id_crc, `FAMILY_CODE};
		`A_TEMP:      rd_data = {16'h0000, temp_reg};
		`A_SCRATCH:   rd_data = {8'h00, cfg_byte, tl_reg, th_reg};
		`A_SCR_CRC:   rd_data = {24'h000000, scr_crc};
		`A_STATUS:    rd_data = {16'h0000, 5'h00, addressed_reg, alarm_reg,
				       func_valid_reg, func_cmd_reg};
		`A_CONV:      rd_data = {4'h0, 4'd9 + {2'b00, res_reg}, 4'h0,
				       conv_us(res_reg)};
		default:      rd_err  = 1'b1;
		endcase
	end

	// Register writes and bus answer flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata        <= 32'h0000_0000;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			serial_lo_reg <= 32'h0000_0000;
			serial_hi_reg <= 16'h0000;
			temp_reg      <= `TEMP_RST;
			th_reg        <= `TH_RST;
			tl_reg        <= `TL_RST;
			res_reg       <= `CFG_RES_RST;
			alarm_reg     <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & rd_err;
			if (psel & ~penable & ~pwrite) begin
				prdata <= rd_data;
			end
			if (wr_en) begin
				case (paddr)
				`A_SERIAL_LO: serial_lo_reg <= pwdata;
				`A_SERIAL_HI: serial_hi_reg <= pwdata[15:0];
				`A_TEMP: begin
					// A write here is a finished conversion
					temp_reg  <= pwdata[15:0];
					alarm_reg <= alarm_check(pwdata[15:0], th_reg,
								 tl_reg);
				end
				`A_SCRATCH: begin
					th_reg  <= pwdata[7:0];
					tl_reg  <= pwdata[15:8];
					res_reg <= {pwdata[16+`CFG_RES_HI_BIT],
						    pwdata[16+`CFG_RES_LO_BIT]};
				end
				default: alarm_reg <= alarm_reg;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- verification/sensor_link_properties.sv
// Port-level assertions for the sensor ROM layer
`timescale 1ns/1ps
`default_nettype none
module sensor_link_properties #(
	parameter int RESET_CYC = 12000
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        dq_in,
	input wire logic        dq_out,
	input wire logic        dq_oe
);
	logic [15:0] low_cnt;
	logic [15:0] hi_cnt;
	logic [15:0] oe_cnt;
	logic        quiet;
	logic        pres;
	logic        oe_q;
	logic        in_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Run lengths of line and drive; quiet holds until the first long low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 16'h0000;
			hi_cnt  <= 16'h0000;
			oe_cnt  <= 16'h0000;
			quiet   <= 1'b1;
			pres    <= 1'b0;
			oe_q    <= 1'b0;
			in_q    <= 1'b1;
		end else begin
			low_cnt <= dq_in ? 16'h0000 : low_cnt + 16'h0001;
			hi_cnt  <= dq_in ? hi_cnt + 16'h0001 : 16'h0000;
			oe_cnt  <= dq_oe ? oe_cnt + 16'h0001 : 16'h0000;
			oe_q    <= dq_oe;
			in_q    <= dq_in;
			if (low_cnt > RESET_CYC)
				quiet <= 1'b0;
			// A drive that starts on a high line can only be presence
			if (dq_oe && !oe_q)
				pres <= in_q;
		end
	end
	sequence s_bus_release;
		$rose(dq_in) && low_cnt > RESET_CYC + 8;
	endsequence
	sequence s_presence_start;
		##[375:1000] $rose(dq_oe);
	endsequence
	a_dq_open_drain: assert property (!dq_out)
		else $error("data output driven high");
	a_pready_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_pready_in_access: assert property
		(pready |-> psel && penable && !$past(penable))
		else $error("ready outside first access cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h1c
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped address not refused");
	a_presence_gap: assert property ($rose(dq_oe) && $past(dq_in)
		|-> $past(hi_cnt) >= 375 && $past(hi_cnt) <= 1500)
		else $error("presence wait out of range");
	a_presence_len: assert property ($fell(dq_oe) && pres
		|-> oe_cnt >= 1500 && oe_cnt <= 6000)
		else $error("presence length out of range");
	a_zero_release: assert property ($fell(dq_oe) && !pres
		|-> oe_cnt <= 800)
		else $error("zero bit held too long");
	a_reset_presence: assert property (s_bus_release |-> s_presence_start)
		else $error("no presence after bus reset");
	a_quiet_power: assert property (quiet |-> !dq_oe)
		else $error("line driven before initialization");
endmodule
bind sensor_link sensor_link_properties #(.RESET_CYC(RESET_CYC)) u_props (
	.pclk    (pclk),
	.presetn (presetn),
	.psel    (psel),
	.penable (penable),
	.pwrite  (pwrite),
	.paddr   (paddr),
	.pwdata  (pwdata),
	.prdata  (prdata),
	.pready  (pready),
	.pslverr (pslverr),
	.dq_in   (dq_in),
	.dq_out  (dq_out),
	.dq_oe   (dq_oe)
);
`default_nettype wire

//--- verification/wire_master_model.sv
// Behavioural single-wire bus master with its own serial CRC
`timescale 1ns/1ps
`default_nettype none
module wire_master_model #(
	parameter int RESET_LOW = 3600
) (
	input  wire logic pclk,
	input  wire logic line_lvl,
	output var  logic pull_low
);
	// Released line idles high through the pull-up
	initial pull_low = 1'b0;
	// Reflected serial step of x^8 + x^5 + x^4 + 1, register starts at zero
	function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		c = c >> 1;
		return fb ? (c ^ 8'h8c) : c;
	endfunction
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Long low resets every slave; presence is looked for after release
	task automatic bus_reset(output logic seen);
		pull_low <= 1'b1;
		wait_cyc(RESET_LOW);
		pull_low <= 1'b0;
		seen = 1'b0;
		repeat (3800) begin
			@(negedge pclk);
			if (line_lvl === 1'b0)
				seen = 1'b1;
		end
		@(posedge pclk);
	endtask
	// Zero keeps the line low past the slave's sample point
	task automatic write_bit(input logic b);
		pull_low <= 1'b1;
		wait_cyc(b ? 20 : 760);
		pull_low <= 1'b0;
		wait_cyc(b ? 750 : 10);
	endtask
	task automatic read_bit(output logic b);
		pull_low <= 1'b1;
		wait_cyc(10);
		pull_low <= 1'b0;
		wait_cyc(290);
		@(negedge pclk);
		b = line_lvl;
		wait_cyc(470);
	endtask
	task automatic write_byte(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			write_bit(d[i]);
	endtask
endmodule
`default_nettype wire

//--- verification/sensor_link_tb.sv
// Self-checking bench: APB registers and single-wire ROM commands
`timescale 1ns/1ps
`default_nettype none
`include "sensor_link_regs.vh"
module sensor_link_tb;
	localparam int         RST_CYC = 3500;
	localparam logic [7:0] FAM     = `FAMILY_CODE;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         dq_out;
	wire         dq_oe;
	wire         pull_low;
	wire         line_lvl;
	int          err_total;
	int          comparisons;
	logic [31:0] q;
	logic        e;
	logic        b;
	logic [7:0]  cfg;
	logic [63:0] id;
	logic [63:0] exp_id;
	// Pull-up wire: low whenever any party pulls it
	assign line_lvl = !(pull_low || (dq_oe && !dq_out));
	sensor_link #(.RESET_CYC(RST_CYC)) u_sensor_link (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.dq_in   (line_lvl),
		.dq_out  (dq_out),
		.dq_oe   (dq_oe)
	);
	wire_master_model u_wire_master_model (
		.pclk     (pclk),
		.line_lvl (line_lvl),
		.pull_low (pull_low)
	);
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	// One APB transfer; the edge that sees pready high completes it
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
			c = u_wire_master_model.crc_bit(c, v[i]);
		return c;
	endfunction
	task automatic summarize();
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Whole run is near 121k cycles, bounded by the slot length
	initial begin
		repeat (130000) @(posedge pclk);
		err_total++;
		summarize();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		comparisons = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `A_TEMP, 32'h0);
		chk_word(q, {16'h0, `TEMP_RST});
		apb(1'b0, `A_SCRATCH, 32'h0);
		chk_word(q, 32'h007f464b);
		apb(1'b0, 8'h20, 32'h0);
		chk_bit(e, 1'b1);
		chk_word(q, 32'h0);
		// Every resolution code, with the scratchpad check byte each time
		for (int i = 0; i < 4; i++) begin
			cfg = {1'b0, i[1:0], 5'h1f};
			apb(1'b1, `A_SCRATCH, {8'h00, cfg, 8'h46, 8'h4b});
			apb(1'b0, `A_CONV, 32'h0);
			chk_word(q, {4'h0, 4'(9 + i), 4'h0, `CONV_US_12 >> (3 - i)});
			apb(1'b0, `A_SCR_CRC, 32'h0);
			chk_word(q, {24'h0, crc_of({`SCR_RSVD7, `SCR_RSVD6, `SCR_RSVD5,
				cfg, 16'h464b, `TEMP_RST}, 64)});
		end
		// In-range result leaves the alarm clear and changes the check byte
		apb(1'b1, `A_TEMP, 32'h0000_0480);
		apb(1'b0, `A_STATUS, 32'h0);
		chk_bit(q[9], 1'b0);
		apb(1'b0, `A_SCR_CRC, 32'h0);
		chk_word(q, {24'h0, crc_of({24'h1000ff, cfg, 16'h464b, 16'h0480},
			64)});
		u_wire_master_model.bus_reset(b);
		chk_bit(b, 1'b1);
		u_wire_master_model.write_byte(`OP_SKIP_ID);
		u_wire_master_model.write_byte(8'h44);
		apb(1'b0, `A_STATUS, 32'h0);
		chk_word({21'h0, q[10:0]}, 32'h0000_0544);
		apb(1'b1, `A_STATUS, 32'h0000_0100);
		apb(1'b0, `A_STATUS, 32'h0);
		chk_bit(q[8], 1'b0);
		// Alarm search with no alarm: device stays off the line
		u_wire_master_model.bus_reset(b);
		u_wire_master_model.write_byte(`OP_ALARM_SEARCH);
		repeat (2) begin
			u_wire_master_model.read_bit(b);
			chk_bit(b, 1'b1);
		end
		apb(1'b1, `A_TEMP, {16'h0, `TEMP_RST});
		apb(1'b0, `A_STATUS, 32'h0);
		chk_bit(q[9], 1'b1);
		// Search: true, complement, then the master picks the other branch
		u_wire_master_model.bus_reset(b);
		u_wire_master_model.write_byte(`OP_SEARCH);
		u_wire_master_model.read_bit(b);
		chk_bit(b, FAM[0]);
		u_wire_master_model.read_bit(b);
		chk_bit(b, !FAM[0]);
		u_wire_master_model.write_bit(!FAM[0]);
		repeat (2) begin
			u_wire_master_model.read_bit(b);
			chk_bit(b, 1'b1);
		end
		u_wire_master_model.write_byte(8'h44);
		apb(1'b0, `A_STATUS, 32'h0);
		chk_bit(q[8], 1'b0);
		// Whole identity read back over the wire
		apb(1'b1, `A_SERIAL_LO, 32'hc3a5_1e69);
		apb(1'b1, `A_SERIAL_HI, 32'h0000_7b2d);
		exp_id = {8'h00, 48'h7b2d_c3a5_1e69, FAM};
		exp_id[63:56] = crc_of(exp_id, 56);
		u_wire_master_model.bus_reset(b);
		u_wire_master_model.write_byte(`OP_READ_ID);
		for (int i = 0; i < 64; i++) begin
			u_wire_master_model.read_bit(b);
			id[i] = b;
		end
		chk_word(id[31:0], exp_id[31:0]);
		chk_word(id[63:32], exp_id[63:32]);
		chk_word({24'h0, crc_of(id, 64)}, 32'h0);
		apb(1'b0, `A_ID_TOP, 32'h0);
		chk_word(q, {16'h0, exp_id[63:56], FAM});
		summarize();
	end
endmodule
`default_nettype wire
